// File: core/osx_pkg.sv
// package: opcodes, cycle counts, register map and flag layout for the core
package osx_pkg;
   // opcodes
   localparam logic [7:0] OP_NOP = 8'hFF;
   localparam logic [7:0] OP_OR_RR_W = 8'h42;
   localparam logic [7:0] OP_OR_RI_W = 8'h43;
   localparam logic [7:0] OP_OR_RR = 8'h44;
   localparam logic [7:0] OP_OR_RI = 8'h45;
   localparam logic [7:0] OP_OR_IMM = 8'h46;
   localparam logic [7:0] OP_POP_R = 8'h50;
   localparam logic [7:0] OP_POP_I = 8'h51;
   localparam logic [7:0] OP_PUSH_R = 8'h70;
   localparam logic [7:0] OP_PUSH_I = 8'h71;
   localparam logic [7:0] OP_UPUSH_DN = 8'h82;
   localparam logic [7:0] OP_UPOP_DN = 8'h92;
   localparam logic [7:0] OP_UPOP_UP = 8'h93;
   // instruction lengths in cycles
   localparam logic [4:0] CYC_NOP = 5'h04;
   localparam logic [4:0] CYC_OR_W = 5'h04;
   localparam logic [4:0] CYC_OR = 5'h06;
   localparam logic [4:0] CYC_STACK = 5'h08;
   // register file locations of the system stack pointer
   localparam logic [7:0] SP_HIGH_ADDR = 8'hD8;
   localparam logic [7:0] SP_LOW_ADDR = 8'hD9;
   localparam logic [15:0] SP_RESET = 16'h0000;
   // working register bank base (r0..r15 live at base + n)
   localparam logic [7:0] WREG_BASE = 8'hC0;
   // flag byte layout: C Z S V D H
   localparam int FLAG_C = 7;
   localparam int FLAG_Z = 6;
   localparam int FLAG_S = 5;
   localparam int FLAG_V = 4;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   // APB register offsets (word indices, byte address bits 9:2)
   localparam logic [7:0] APB_SP_HIGH = 8'hD8;
   localparam logic [7:0] APB_SP_LOW = 8'hD9;
   localparam logic [7:0] APB_FLAGS = 8'h00;
   localparam logic [7:0] APB_STATUS = 8'h04;
   localparam logic [7:0] APB_LAST_OP = 8'h08;
   // the SP low offset D9 is not a multiple of four, so offsets are indices
   localparam logic [11:0] APB_WORD_SHIFT = 12'h002;
endpackage : osx_pkg

// File: core/osx_regfile.sv
// register file: 256 bytes, one write port, two read ports
module osx_regfile (
   input wire logic clk_i,         // core clock
   input wire logic we_i,          // write strobe
   input wire logic [7:0] waddr_i, // write address
   input wire logic [7:0] wdata_i, // write data
   input wire logic [7:0] raddr_a_i, // read port a address
   output logic [7:0] rdata_a_o,   // read port a data
   input wire logic [7:0] raddr_b_i, // read port b address
   output logic [7:0] rdata_b_o    // read port b data
);
   logic [7:0] mem [0:255];

   // storage has no reset; software initialises it as on the real core
   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
   end

   // combinational reads keep each instruction step to one cycle
   assign rdata_a_o = mem[raddr_a_i];
   assign rdata_b_o = mem[raddr_b_i];
endmodule : osx_regfile

// File: core/osx_core.sv
// execution core for nop, or, and system and user stack instructions
//
// Notes on behaviour
// [RULE1] opcode FF is a one-byte nop, 4 cycles, changes nothing
// [RULE2] or writes dst OR src into dst, source untouched
// [RULE3] or sets zero, copies bit 7 to sign, clears overflow
// [RULE4] or opcodes 42..46: 42 takes 4 cycles, others 6
// [RULE5] pop 50/51 loads byte at sp into dst, then sp+1, 8 cycles
// [RULE6] stack pointer is high byte at D8, low byte at D9, 16 bits
// [RULE7] push 70/71 decrements sp first, then stores source, 8 cycles
// [RULE8] pop user decrementing 92: copy byte at pointer, then pointer-1
// [RULE9] pop user incrementing 93: copy byte at pointer, then pointer+1
// [RULE10] push user decrementing 82: pointer-1, then store source there
// [RULE11] user stacks and their pointers live in the register file
// [RULE12] stack instructions leave every flag unchanged
// [RULE13] indirect forms read a register, then use it as operand address
module osx_core (
   input wire logic REF_CLK_I,      // 200 MHz core clock
   input wire logic RST_I,          // synchronous reset, active high
   input wire logic INSTR_VALID_I,  // instruction bytes valid
   input wire logic [7:0] OPC_I,    // opcode byte
   input wire logic [7:0] B1_I,     // first operand byte
   input wire logic [7:0] B2_I,     // second operand byte
   output logic INSTR_READY_O,      // core takes an instruction
   output logic DONE_O,             // pulse: instruction retired
   output logic ILLEGAL_O,          // pulse: opcode not handled here
   output logic [7:0] FLAGS_O,      // flag byte
   output logic [15:0] SP_O,        // system stack pointer
   input wire logic PSEL,           // apb select
   input wire logic PENABLE,        // apb enable
   input wire logic PWRITE,         // apb direction
   input wire logic [11:0] PADDR,   // apb byte address
   input wire logic [31:0] PWDATA,  // apb write data
   output logic [31:0] PRDATA,      // apb read data
   output logic PREADY,             // apb ready
   output logic PSLVERR             // apb error
);
   // gray coded along idle -> fetch -> exec -> wait
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_IND = 2'b01,
      ST_EXEC = 2'b11,
      ST_WAIT = 2'b10
   } osx_state_type;

   typedef struct packed {
      osx_state_type st;
      logic [7:0] opc;
      logic [7:0] b1;
      logic [7:0] b2;
      logic [7:0] ind;     // address fetched for an indirect operand
      logic [4:0] cnt;     // cycles left in the instruction
      logic [15:0] sp;
      logic [7:0] flags;
      logic [7:0] last_op;
      logic ready;
      logic done;
      logic illegal;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } osx_regs_type;

   osx_regs_type r, rn;
   logic rf_we;
   logic [7:0] rf_waddr, rf_wdata, ra_a, ra_b, rd_a, rd_b, rv_a, rv_b;

   osx_regfile u_rf (
      .clk_i(REF_CLK_I),
      .we_i(rf_we),
      .waddr_i(rf_waddr),
      .wdata_i(rf_wdata),
      .raddr_a_i(ra_a),
      .rdata_a_o(rd_a),
      .raddr_b_i(ra_b),
      .rdata_b_o(rd_b)
   );

   // working register nibble to register file address
   function automatic logic [7:0] wreg(input logic [3:0] n);
      return osx_pkg::WREG_BASE | {4'h0, n};
   endfunction : wreg

   // instruction length lookup, shared by decode and the user-pop wait state
   function automatic logic [4:0] op_cycles(input logic [7:0] op);
      case (op)
         osx_pkg::OP_NOP: return osx_pkg::CYC_NOP; // [RULE1]
         osx_pkg::OP_OR_RR_W: return osx_pkg::CYC_OR_W; // [RULE4]
         osx_pkg::OP_OR_RI_W, osx_pkg::OP_OR_RR, osx_pkg::OP_OR_RI,
         osx_pkg::OP_OR_IMM: return osx_pkg::CYC_OR; // [RULE4]
         osx_pkg::OP_POP_R, osx_pkg::OP_POP_I, osx_pkg::OP_PUSH_R,
         osx_pkg::OP_PUSH_I, osx_pkg::OP_UPUSH_DN, osx_pkg::OP_UPOP_DN,
         osx_pkg::OP_UPOP_UP: return osx_pkg::CYC_STACK;
         default: return 5'h00;
      endcase
   endfunction : op_cycles

   // true when the opcode uses an indirect operand
   function automatic logic is_ind(input logic [7:0] op);
      return op == osx_pkg::OP_OR_RI_W || op == osx_pkg::OP_OR_RI ||
         op == osx_pkg::OP_POP_I || op == osx_pkg::OP_PUSH_I ||
         op == osx_pkg::OP_UPUSH_DN || op == osx_pkg::OP_UPOP_DN ||
         op == osx_pkg::OP_UPOP_UP;
   endfunction : is_ind

   // address of the register to read first for an indirect form
   function automatic logic [7:0] ptr_addr(input logic [7:0] op,
                                           input logic [7:0] a,
                                           input logic [7:0] b);
      case (op)
         osx_pkg::OP_OR_RI_W: return wreg(a[3:0]);
         osx_pkg::OP_OR_RI, osx_pkg::OP_UPOP_DN, osx_pkg::OP_UPOP_UP: return a;
         osx_pkg::OP_POP_I, osx_pkg::OP_PUSH_I, osx_pkg::OP_UPUSH_DN: return a;
         default: return b;
      endcase
   endfunction : ptr_addr
   // sp bytes answer at their register addresses, not from storage
   function automatic logic [7:0] rf_view(logic [15:0] s, logic [7:0] a, d);
      if (a == osx_pkg::SP_HIGH_ADDR) return s[15:8]; // [RULE6]
      if (a == osx_pkg::SP_LOW_ADDR) return s[7:0]; // [RULE6]
      return d;
   endfunction : rf_view

   logic apb_acc, apb_wr;
   logic [7:0] apb_idx;
   logic [8:0] or_res;
   logic [15:0] sp_dec;

   // apb index: byte address divided by the word size
   assign apb_idx = PADDR[9:2];
   assign apb_acc = PSEL && PENABLE && !r.pready;
   assign apb_wr = apb_acc && PWRITE;
   assign sp_dec = r.sp - 16'h0001; // [RULE6]

   // register-file read port addressing per state
   always_comb begin
      ra_a = 8'h00;
      ra_b = 8'h00;
      or_res = 9'h000;
      if (r.st == osx_state_type'(ST_IND)) begin
         ra_a = ptr_addr(r.opc, r.b1, r.b2); // [RULE13]
      end else begin
         case (r.opc)
            osx_pkg::OP_OR_RR_W: begin
               ra_a = wreg(r.b1[7:4]);
               ra_b = wreg(r.b1[3:0]);
            end
            osx_pkg::OP_OR_RI_W: begin
               ra_a = wreg(r.b1[7:4]);
               ra_b = r.ind; // [RULE13]
            end
            osx_pkg::OP_OR_RR: begin
               ra_a = r.b2;
               ra_b = r.b1;
            end
            osx_pkg::OP_OR_RI: begin
               ra_a = r.b2;
               ra_b = r.ind; // [RULE13]
            end
            osx_pkg::OP_OR_IMM: ra_a = r.b1;
            osx_pkg::OP_POP_R, osx_pkg::OP_POP_I:
               ra_b = r.sp[7:0]; // [RULE5]
            osx_pkg::OP_PUSH_R: ra_b = r.b1;
            osx_pkg::OP_PUSH_I: ra_b = r.ind;
            osx_pkg::OP_UPUSH_DN: ra_b = r.b2;
            osx_pkg::OP_UPOP_DN, osx_pkg::OP_UPOP_UP:
               ra_b = r.ind; // [RULE11]
            default: ra_a = 8'h00;
         endcase
      end
      rv_a = rf_view(r.sp, ra_a, rd_a); // [RULE6]
      rv_b = rf_view(r.sp, ra_b, rd_b); // [RULE6]
      or_res = {1'b0, rv_a | (r.opc == osx_pkg::OP_OR_IMM ? r.b2 : rv_b)};
   end

   // next-state logic: decode, execute, wait out the cycle count, apb
   always_comb begin
      rn = r;
      rn.done = 1'b0;
      rn.illegal = 1'b0;
      rn.pready = 1'b0;
      rn.pslverr = 1'b0;
      rf_we = 1'b0;
      rf_waddr = 8'h00;
      rf_wdata = 8'h00;
      case (r.st)
         ST_IDLE: begin
            if (INSTR_VALID_I && r.ready) begin
               rn.ready = 1'b0;
               rn.opc = OPC_I;
               rn.b1 = B1_I;
               rn.b2 = B2_I;
               rn.last_op = OPC_I;
               if (op_cycles(OPC_I) == 5'h00) begin
                  rn.illegal = 1'b1;
                  rn.done = 1'b1;
                  rn.ready = 1'b1;
               end else begin
                  rn.cnt = op_cycles(OPC_I) - 5'h01;
                  rn.st = is_ind(OPC_I) ? ST_IND : ST_EXEC;
               end
            end
         end
         ST_IND: begin
            rn.ind = rv_a; // [RULE13]
            rn.cnt = r.cnt - 5'h01;
            rn.st = ST_EXEC;
            // user pushes move the pointer before storing
            if (r.opc == osx_pkg::OP_UPUSH_DN) begin
               rn.ind = rv_a - 8'h01; // [RULE10]
               rf_we = 1'b1;
               rf_waddr = r.b1;
               rf_wdata = rv_a - 8'h01; // [RULE10]
            end
         end
         ST_EXEC: begin
            rn.cnt = r.cnt - 5'h01;
            rn.st = ST_WAIT;
            case (r.opc)
               osx_pkg::OP_OR_RR_W, osx_pkg::OP_OR_RI_W, osx_pkg::OP_OR_RR,
               osx_pkg::OP_OR_RI, osx_pkg::OP_OR_IMM: begin
                  rf_we = 1'b1;
                  rf_waddr = ra_a;
                  rf_wdata = or_res[7:0]; // [RULE2]
                  rn.flags[osx_pkg::FLAG_Z] = or_res[7:0] == 8'h00; // [RULE3]
                  rn.flags[osx_pkg::FLAG_S] = or_res[7]; // [RULE3]
                  rn.flags[osx_pkg::FLAG_V] = 1'b0; // [RULE3]
               end
               osx_pkg::OP_POP_R, osx_pkg::OP_POP_I: begin // [RULE12]
                  rf_we = 1'b1;
                  rf_waddr = r.opc == osx_pkg::OP_POP_I ? r.ind : r.b1;
                  rf_wdata = rv_b; // [RULE5]
                  rn.sp = r.sp + 16'h0001; // [RULE5] [RULE6]
               end
               osx_pkg::OP_PUSH_R, osx_pkg::OP_PUSH_I: begin
                  rn.sp = sp_dec; // [RULE7]
                  rf_we = 1'b1;
                  rf_waddr = sp_dec[7:0]; // [RULE7]
                  rf_wdata = rv_b;
               end
               osx_pkg::OP_UPUSH_DN: begin
                  rf_we = 1'b1;
                  rf_waddr = r.ind; // [RULE10]
                  rf_wdata = rv_b;
               end
               osx_pkg::OP_UPOP_DN, osx_pkg::OP_UPOP_UP: begin
                  rf_we = 1'b1;
                  rf_waddr = r.b2;
                  rf_wdata = rv_b; // [RULE8] [RULE9]
                  rn.b2 = r.opc == osx_pkg::OP_UPOP_DN ? r.ind - 8'h01
                                                        : r.ind + 8'h01;
               end
               default: rn.st = ST_WAIT; // nop: only the delay [RULE1]
            endcase
         end
         ST_WAIT: begin
            // user pops update their pointer after the copy
            if (r.opc inside {osx_pkg::OP_UPOP_DN, osx_pkg::OP_UPOP_UP}) begin
               if (r.cnt == op_cycles(r.opc) - 5'h03) begin
                  rf_we = 1'b1;
                  rf_waddr = r.b1; // [RULE8] [RULE9]
                  rf_wdata = r.b2;
               end
            end
            if (r.cnt == 5'h01) begin
               rn.st = ST_IDLE;
               rn.done = 1'b1;
               rn.ready = 1'b1;
            end
            rn.cnt = r.cnt - 5'h01;
         end
         default: rn.st = ST_IDLE;
      endcase
      // writes to the sp addresses land in the pointer itself [RULE6]
      if (rf_we && rf_waddr == osx_pkg::SP_HIGH_ADDR) rn.sp[15:8] = rf_wdata;
      if (rf_we && rf_waddr == osx_pkg::SP_LOW_ADDR) rn.sp[7:0] = rf_wdata;
      // apb slave: one wait state, core execution has priority for sp
      if (apb_acc) begin
         rn.pready = 1'b1;
         rn.prdata = 32'h0000_0000;
         case (apb_idx)
            osx_pkg::APB_SP_HIGH: begin
               rn.prdata = {24'h000000, r.sp[15:8]};
               if (apb_wr && r.st == ST_IDLE) rn.sp[15:8] = PWDATA[7:0];
            end
            osx_pkg::APB_SP_LOW: begin
               rn.prdata = {24'h000000, r.sp[7:0]};
               if (apb_wr && r.st == ST_IDLE) rn.sp[7:0] = PWDATA[7:0];
            end
            osx_pkg::APB_FLAGS: begin
               rn.prdata = {24'h000000, r.flags};
               if (apb_wr && r.st == ST_IDLE) rn.flags = PWDATA[7:0];
            end
            osx_pkg::APB_STATUS:
               rn.prdata = {27'h0000000, r.cnt};
            osx_pkg::APB_LAST_OP:
               rn.prdata = {24'h000000, r.last_op};
            default: rn.pslverr = 1'b1;
         endcase
      end
      if (RST_I) begin
         rn = '0;
         rn.st = ST_IDLE;
         rn.sp = osx_pkg::SP_RESET;
         rn.flags = osx_pkg::FLAGS_RESET;
         rn.ready = 1'b1;
      end
   end

   // single state register
   always_ff @(posedge REF_CLK_I) begin
      r <= rn;
   end

   assign INSTR_READY_O = r.ready;
   assign DONE_O = r.done;
   assign ILLEGAL_O = r.illegal;
   assign FLAGS_O = r.flags;
   assign SP_O = r.sp;
   assign PRDATA = r.prdata;
   assign PREADY = r.pready;
   assign PSLVERR = r.pslverr;

   // cycles from acceptance to done, for timing checks
   logic [4:0] age;
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I || r.ready) age <= 5'h01;
      else age <= age + 5'h01;
   end

   a_nop_timing: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      (DONE_O && !ILLEGAL_O && r.opc == osx_pkg::OP_NOP) |-> age == 5'h04)
      else $error("nop length wrong"); // [RULE1]
   a_nop_flags: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      (r.st != ST_IDLE && r.opc == osx_pkg::OP_NOP) |=> $stable(r.flags))
      else $error("nop changed flags"); // [RULE1]
   a_or_value: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      (r.st == ST_EXEC && r.opc == osx_pkg::OP_OR_IMM) |->
      rf_wdata == (rv_a | r.b2))
      else $error("or result wrong"); // [RULE2]
   a_or_flags: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      (r.st == ST_EXEC && r.opc[7:3] == 5'b01000 && rf_we) |=>
      FLAGS_O[osx_pkg::FLAG_V] == 1'b0 &&
      FLAGS_O[osx_pkg::FLAG_S] == $past(rf_wdata[7]))
      else $error("or flags wrong"); // [RULE3]
   a_or_timing: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      (DONE_O && !ILLEGAL_O && r.opc == osx_pkg::OP_OR_RR) |-> age == 5'h06)
      else $error("or length wrong"); // [RULE4]
   a_pop_sp_inc: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      (r.st == ST_EXEC && r.opc == osx_pkg::OP_POP_R) |=>
      SP_O == $past(SP_O) + 16'h0001)
      else $error("pop sp wrong"); // [RULE5]
   a_push_sp_dec: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      (r.st == ST_EXEC && r.opc == osx_pkg::OP_PUSH_R) |->
      rf_waddr == sp_dec[7:0] ##1 SP_O == $past(sp_dec))
      else $error("push order wrong"); // [RULE7]
   a_stack_timing: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      (DONE_O && !ILLEGAL_O && r.opc[7:4] != 4'h4 &&
      r.opc != osx_pkg::OP_NOP) |-> age == 5'h08)
      else $error("stack length wrong"); // [RULE5] [RULE8] [RULE9] [RULE10]
   a_stack_flags: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
      (r.st == ST_EXEC && r.opc[7:4] != 4'h4 && !apb_wr) |=>
      $stable(FLAGS_O))
      else $error("stack changed flags"); // [RULE12]
endmodule : osx_core

// File: dv/osx_imem_model.sv
// partner: instruction fetch path handing the core one instruction
module osx_imem_model (
   input wire logic clk_i,    // core clock
   input wire logic ready_i,  // core takes an instruction
   input wire logic done_i,   // retire pulse
   input wire logic ill_i,    // illegal pulse
   output logic valid_o,      // instruction valid
   output logic [7:0] opc_o,  // opcode byte
   output logic [7:0] b1_o,   // first operand byte
   output logic [7:0] b2_o    // second operand byte
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      valid_o = 1'b0;
      {opc_o, b1_o, b2_o} = 24'h00FFFF;
   end
   // present after a stall, hold until taken, count edges until retire
   task automatic issue(input logic [7:0] op, a, b, input int stall,
         output int cyc, output logic ill);
      cyc = 0;
      repeat (stall) @(posedge clk_i);
      valid_o <= 1'b1;
      {opc_o, b1_o, b2_o} <= {op, a, b};
      @(posedge clk_i);
      while (ready_i !== 1'b1) @(posedge clk_i);
      // released bytes show the inverse so stale bytes never look valid
      valid_o <= 1'b0;
      {opc_o, b1_o, b2_o} <= ~{op, a, b};
      do begin
         @(posedge clk_i);
         cyc++;
      end while (done_i !== 1'b1 && cyc < 40);
      ill = ill_i;
   endtask : issue
endmodule : osx_imem_model

// File: dv/test_cpu_or_stack_instr_exec.sv
// testbench: or, nop and stack instructions seen through sp, flags, apb
module test_cpu_or_stack_instr_exec;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, valid, ready, done, ill;
   logic [7:0] opc, b1, b2, flags, expf = 8'h00, lfsr = 8'h4E;
   logic [15:0] sp;
   logic [7:0] op_t[5] = '{8'h42, 8'h43, 8'h44, 8'h45, 8'h46};
   logic [7:0] b1_t[5] = '{8'h35, 8'h36, 8'h31, 8'h32, 8'h30};
   int failures = 0, total_checks = 0, cycles = 0;
   osx_core dut_u (.REF_CLK_I(clk), .RST_I(rst), .INSTR_VALID_I(valid),
      .OPC_I(opc), .B1_I(b1), .B2_I(b2), .INSTR_READY_O(ready),
      .DONE_O(done), .ILLEGAL_O(ill), .FLAGS_O(flags), .SP_O(sp),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr));
   osx_imem_model feed_u (.clk_i(clk), .ready_i(ready), .done_i(done),
      .ill_i(ill), .valid_o(valid), .opc_o(opc), .b1_o(b1), .b2_o(b2));
   always #2.5 clk = ~clk;
   // a hang anywhere ends here; the run needs only a few thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         summarize();
      end
   end
   task automatic summarize();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : summarize
   task automatic chk(input string w, input logic [31:0] e, g);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", w, e, g);
      end
   endtask : chk
   // eight-bit lfsr, taps 8 6 5 4
   function automatic logic [7:0] rnd();
      lfsr = {lfsr[6:0], ^(lfsr & 8'hB8)};
      return lfsr;
   endfunction : rnd
   // flags after or: carry and low bits kept, overflow forced low
   function automatic logic [7:0] orf(input logic [7:0] f, r);
      return {f[7], r == 8'h00, r[7], 1'b0, f[3:0]};
   endfunction : orf
   // one apb transfer; a spare edge after release avoids a double drive
   task automatic apb(input logic wr, input logic [7:0] idx,
         input logic [31:0] wd, output logic [31:0] rd, output logic er);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic wr(input logic [7:0] idx, d);
      logic [31:0] r;
      logic er;
      apb(1'b1, idx, {24'h0, d}, r, er);
   endtask : wr
   task automatic rd(input logic [7:0] idx, e, input logic ee);
      logic [31:0] r;
      logic er;
      apb(1'b0, idx, 32'h0, r, er);
      chk("prdata", {24'h0, e}, r);
      chk("pslverr", ee, er);
   endtask : rd
   // one instruction with a random stall; checks after the retire edge
   task automatic run(input logic [7:0] op, x, y, input int n,
         input logic [15:0] esp);
      int c;
      logic il;
      feed_u.issue(op, x, y, int'(lfsr[1:0]), c, il);
      @(posedge clk);
      chk("retire cycles", n, c);
      chk("illegal", n == 1, il);
      chk("flags", expf, flags);
      chk("sp", esp, sp);
   endtask : run
   // park v in register r: push it from the sp high byte, pop into r
   task automatic put(input logic [7:0] r, v);
      wr(osx_pkg::APB_SP_HIGH, v);
      wr(osx_pkg::APB_SP_LOW, 8'h51);
      run(osx_pkg::OP_PUSH_R, 8'hD8, 8'h00, 8, {v, 8'h50});
      run(osx_pkg::OP_POP_R, r, 8'h00, 8, {v, 8'h51});
   endtask : put
   // reveal register r by or-ing it into a cleared sp high byte
   task automatic show(input logic [7:0] r, e, lo);
      wr(osx_pkg::APB_SP_HIGH, 8'h00);
      expf = orf(expf, e);
      run(osx_pkg::OP_OR_RR, r, 8'hD8, 6, {e, lo});
   endtask : show
   initial begin
      logic [7:0] a, b, v, w;
      int m;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      chk("ready", 1'b1, ready);
      chk("flags", 8'h00, flags);
      chk("sp", 16'h0000, sp);
      rd(8'h10, 8'h00, 1'b1);
      wr(osx_pkg::APB_SP_HIGH, 8'h12);
      wr(osx_pkg::APB_SP_LOW, 8'h34);
      chk("sp", 16'h1234, sp);
      rd(osx_pkg::APB_SP_LOW, 8'h34, 1'b0);
      $display("test registers done");
      // first pass all zero operands, then random ones
      for (int k = 0; k < 10; k++) begin
         m = k % 5;
         a = (k < 5) ? 8'h00 : rnd();
         b = (k < 5) ? 8'h00 : rnd();
         expf = rnd() & 8'hFC;
         wr(osx_pkg::APB_FLAGS, expf);
         put(8'h30, a);
         put(8'hC3, a);
         put(8'hC5, b);
         put(8'hC6, 8'h31);
         put(8'h31, b);
         put(8'h32, 8'h31);
         expf = orf(expf, a | b);
         run(op_t[m], b1_t[m], (m == 4) ? b : 8'h30, (m == 0) ? 4 : 6,
            16'h3151);
         show((m < 2) ? 8'hC3 : 8'h30, a | b, 8'h51);
         show((m == 0) ? 8'hC5 : 8'h31, b, 8'h51);
      end
      $display("test or forms done");
      v = rnd();
      put(8'h20, 8'h41);
      put(8'h31, v);
      run(osx_pkg::OP_UPUSH_DN, 8'h20, 8'h31, 8, {v, 8'h51});
      show(8'h20, 8'h40, 8'h51);
      show(8'h40, v, 8'h51);
      run(osx_pkg::OP_UPOP_DN, 8'h20, 8'h30, 8, {v, 8'h51});
      show(8'h30, v, 8'h51);
      show(8'h20, 8'h3F, 8'h51);
      w = rnd();
      put(8'h3F, w);
      run(osx_pkg::OP_UPOP_UP, 8'h20, 8'h30, 8, {w, 8'h51});
      show(8'h30, w, 8'h51);
      show(8'h20, 8'h40, 8'h51);
      $display("test user stacks done");
      put(8'h33, 8'h30);
      put(8'h34, 8'h35);
      wr(osx_pkg::APB_SP_HIGH, 8'h01);
      wr(osx_pkg::APB_SP_LOW, 8'h00);
      run(osx_pkg::OP_PUSH_I, 8'h33, 8'h00, 8, 16'h00FF);
      run(osx_pkg::OP_POP_I, 8'h34, 8'h00, 8, 16'h0100);
      show(8'h35, w, 8'h00);
      $display("test stack carry done");
      run(osx_pkg::OP_NOP, 8'h00, 8'h00, 4, {w, 8'h00});
      run(osx_pkg::OP_NOP, 8'hFF, 8'hFF, 4, {w, 8'h00});
      rd(osx_pkg::APB_LAST_OP, 8'hFF, 1'b0);
      run(8'h00, 8'h00, 8'h00, 1, {w, 8'h00});
      // idle core has no cycles left to count
      rd(osx_pkg::APB_STATUS, 8'h00, 1'b0);
      $display("test nop and illegal done");
      summarize();
   end
endmodule : test_cpu_or_stack_instr_exec
